// *** fwsr_flash_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Flash status model
// ----------------------------------------
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input wire logic clk,
  input wire fwsr_pins_t pins,
  input wire logic [15:0] bus_i,
  input wire logic arm,
  input wire logic [7:0] arm_reads,
  input wire logic [15:0] arm_datum,
  input wire logic arm_erase,
  input wire logic arm_fail,
  input wire logic arm_prot,
  input wire logic suspend,
  output logic [15:0] dq,
  output logic ready_busy,
  output logic [7:0] resets_seen
);
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic tog2 = 1'b0;
  logic lim = 1'b0;
  logic rd_q = 1'b0;
  logic we_q = 1'b0;
  logic ers = 1'b0;
  logic flt = 1'b0;
  logic prot = 1'b0;
  logic [7:0] left = 8'h01;
  logic [15:0] arr = 16'h1234;
  logic [15:0] dat = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] stat;
  logic rd;
  logic p7;
  logic [7:0] rst_cnt = 8'h00;

  // Bit 7 turns true one read early while the upper lines are still stale
  assign rd = !pins.ce_n && !pins.oe_n;
  // Suspended erase reads one; a protected target never shows true data
  assign p7 = suspend ? 1'b1 :
              (left == 8'h01 && !flt && !prot) ? dat[7] : ~dat[7];
  assign stat = {~dat[15:8], p7, tog, lim, 1'b0, ers, tog2, 2'b11};
  // Released lines show the inverse of the last value, so no stale word passes
  assign dq = rd ? (busy ? stat : arr) : ~last;
  assign ready_busy = (busy && !suspend) ? 1'b0 : 1'b1;
  assign resets_seen = rst_cnt;

  // Each finished read while busy advances tog unless suspended and tog2 during erase; the reset command ends the operation
  always @(posedge clk) begin
    rd_q <= rd;
    we_q <= !pins.we_n;
    if (rd) last <= dq;
    if (!pins.we_n) cmd <= bus_i;
    if (arm) begin
      busy <= 1'b1;
      left <= arm_reads;
      dat <= arm_datum;
      ers <= arm_erase;
      flt <= arm_fail;
      prot <= arm_prot;
      lim <= 1'b0;
    end else if (rd_q && !rd && busy) begin
      if (!suspend) tog <= ~tog;
      if (ers) tog2 <= ~tog2;
      if (flt) lim <= 1'b1;
      else if (!suspend && left == 8'h01) begin
        busy <= 1'b0;
        // Protected words are skipped: the bank goes back to array reads unchanged
        if (!prot) arr <= dat;
      end else if (!suspend) left <= left - 8'h01;
    end
    if (we_q && pins.we_n && cmd == RESET_CMD) begin
      busy <= 1'b0;
      lim <= 1'b0;
      rst_cnt <= rst_cnt + 8'h01;
    end
  end
endmodule

// *** fwsr_host_ctrl.sv ***
`timescale 1ns/10ps
// Operation
// RULE1 - Device shows inverted bit 7 of written datum while programming, true afterwards.
// RULE2 - Status outputs become valid from the last write strobe rising edge.
// RULE3 - Program into protected sector: polling bit active about 1 us, then read mode.
// RULE4 - Erase drives polling bit 0; 1 after completion or erase suspend.
// RULE5 - All erase sectors protected: polling and toggling about 400 us, then read mode.
// RULE6 - Partly protected erase skips protected sectors; their status may be invalid.
// RULE7 - Host polls at the program address or inside a sector being erased.
// RULE8 - After polling bit shows true data, host takes full word from next read.
// RULE9 - Ready/busy output low while programming or erasing, released otherwise.
// RULE10 - First toggle bit inverts on each read while busy, stops when done.
// RULE11 - First toggle bit readable anywhere, toggles during erase time-out too.
// RULE12 - Program to protected sector toggles first toggle bit about 1 us.
// RULE13 - Erase suspend stops toggling; suspend-program toggles again until done.
// RULE14 - Second toggle bit inverts on reads within sectors selected for erase.
// RULE15 - Toggle polling starts with two reads compared; unchanged means done.
// RULE16 - Still toggling with limit flag high: check once more, else fail and reset.
// RULE17 - After interrupting polling, host restarts the whole check from the start.
// RULE18 - Data polling rechecks polling bit even after limit flag reads one.
// RULE19 - Limit flag set to one when pulse-count limit exceeded.
// RULE20 - Status read to an idle bank returns array data.
// RULE21 - Erase-timer flag 0 during erase time-out, 1 when erasing begins.
// RULE22 - Toggle state advances once per completed read cycle.
module fwsr_host_ctrl
  import fwsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fwsr_pins_t flash_pins,
  input wire logic [15:0] flash_dq_i,
  input wire logic flash_ready_busy_i
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_ADDR) || (a == OFF_EXPECT) ||
                (a == OFF_STATUS) || (a == OFF_RESULT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  localparam logic [3:0] READ_LAST = 4'(READ_CYC - 1);
  localparam logic [3:0] WE_LAST = 4'(WE_CYC - 1);

  // ----------------------------------------------------------------
  // Bus slave and software registers
  // ----------------------------------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  fwsr_mode_t mode_q, mode_d;
  logic [22:0] addr_q, addr_d;
  logic [15:0] expect_q, expect_d;
  logic start_p, abort_p, wr_fire;
  logic busy_q, done_q, fail_q;
  logic [15:0] result_q;

  // Write fires once both halves are held; reads answer one cycle after address
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    addr_d = addr_q;
    expect_d = expect_q;
    start_p = 1'b0;
    abort_p = 1'b0;
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(awaddr_q) ? 2'b00 : 2'b10;
      if (awaddr_q == OFF_CTRL && wstrb_q[0]) begin
        // Start while busy is ignored; a fresh start begins at the first read unless abort is set in the same write
        start_p = wdata_q[CTRL_START] && !busy_q;
        abort_p = wdata_q[CTRL_ABORT];
        if (!busy_q) mode_d = fwsr_mode_t'(wdata_q[CTRL_MODE]);
      end
      if (awaddr_q == OFF_ADDR) addr_d = 23'(merge({9'h000, addr_q}, wdata_q, wstrb_q));
      if (awaddr_q == OFF_EXPECT) expect_d = 16'(merge({16'h0000, expect_q}, wdata_q, wstrb_q));
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        OFF_CTRL: rdata_d = {30'h00000000, mode_q, 1'b0};
        OFF_ADDR: rdata_d = {9'h000, addr_q};
        OFF_EXPECT: rdata_d = {16'h0000, expect_q};
        OFF_STATUS: rdata_d = {28'h0000000, !flash_ready_busy_i, fail_q, done_q, busy_q};
        OFF_RESULT: rdata_d = {16'h0000, result_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // Ready outputs are registered copies of the free holding slots
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
  end

  // Bus and register flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h00000000;
      mode_q <= FWSR_MODE_DATA;
      addr_q <= ADDR_RST;
      expect_q <= EXPECT_RST;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      expect_q <= expect_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Status polling sequencer
  // ----------------------------------------------------------------
  fwsr_state_t st_q, st_d;
  fwsr_phase_t ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] rd_q, rd_d, result_d;
  logic prev_q, prev_d, busy_d, done_d, fail_d;
  fwsr_pins_t pins_q, pins_d;
  logic match, same;

  assign match = rd_q[DQ_POLL] == expect_q[DQ_POLL];
  assign same = rd_q[DQ_TOG1] == prev_q;

  // Each read is a full strobe cycle closed by an idle cycle, so the toggle bits advance
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    prev_d = prev_q;
    busy_d = busy_q;
    done_d = done_q;
    fail_d = fail_q;
    result_d = result_q;
    unique case (st_q)
      FWSR_IDLE: begin
        if (start_p) begin
          st_d = FWSR_READ; // RULE17
          ph_d = FWSR_PH_FIRST; // RULE17
          cnt_d = READ_LAST;
          busy_d = 1'b1;
          done_d = 1'b0;
          fail_d = 1'b0;
        end
      end
      FWSR_READ: begin
        if (cnt_q == 4'h0) begin
          rd_d = flash_dq_i;
          st_d = FWSR_EVAL;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      FWSR_EVAL: begin
        st_d = FWSR_READ;
        cnt_d = READ_LAST;
        prev_d = rd_q[DQ_TOG1];
        if (ph_q == FWSR_PH_FINAL) begin
          st_d = FWSR_IDLE; // RULE8
          result_d = rd_q;
          busy_d = 1'b0;
          done_d = 1'b1;
        end else if (mode_q == FWSR_MODE_DATA) begin
          if (match) ph_d = FWSR_PH_FINAL; // RULE8
          else if (ph_q == FWSR_PH_RECHECK) st_d = FWSR_WRITE; // RULE16
          else if (rd_q[DQ_LIMIT]) ph_d = FWSR_PH_RECHECK; // RULE18
          else ph_d = FWSR_PH_POLL;
        end else begin
          if (ph_q == FWSR_PH_FIRST) ph_d = FWSR_PH_POLL; // RULE15
          else if (same) ph_d = FWSR_PH_FINAL; // RULE15
          else if (ph_q == FWSR_PH_RECHECK) st_d = FWSR_WRITE; // RULE16
          else if (rd_q[DQ_LIMIT]) ph_d = FWSR_PH_RECHECK; // RULE16
        end
        if (st_d == FWSR_WRITE) cnt_d = WE_LAST;
      end
      FWSR_WRITE: begin
        // Reset command returns the bank to array reads after a failure
        if (cnt_q == 4'h0) begin
          st_d = FWSR_IDLE;
          busy_d = 1'b0;
          fail_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    endcase
    if (abort_p) begin
      st_d = FWSR_IDLE; // RULE17
      busy_d = 1'b0;
    end
    pins_d.ce_n = !(st_d == FWSR_READ || st_d == FWSR_WRITE);
    pins_d.oe_n = !(st_d == FWSR_READ);
    pins_d.we_n = !(st_d == FWSR_WRITE);
    pins_d.dq_oe_n = !(st_d == FWSR_WRITE);
    pins_d.dq_o = RESET_CMD;
    pins_d.addr = addr_q; // RULE7
  end

  // Sequencer flip-flops; pins come straight from here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FWSR_IDLE;
      ph_q <= FWSR_PH_FIRST;
      cnt_q <= 4'h0;
      rd_q <= 16'h0000;
      prev_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      result_q <= 16'h0000;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                  dq_o: 16'h0000, addr: 23'h000000};
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      prev_q <= prev_d;
      busy_q <= busy_d;
      done_q <= done_d;
      fail_q <= fail_d;
      result_q <= result_d;
      pins_q <= pins_d;
    end
  end

  assign flash_pins = pins_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_eval_now;
    st_q == FWSR_EVAL && ph_q != FWSR_PH_FINAL && !abort_p;
  endsequence

  sequence s_final_read;
    st_q == FWSR_READ && ph_q == FWSR_PH_FINAL && !pins_q.oe_n;
  endsequence

  a_poll_address: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    !pins_q.oe_n |-> pins_q.addr == $past(addr_q))
    else $error("Status read not at the poll address");

  a_true_then_word: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    (s_eval_now and mode_q == FWSR_MODE_DATA && match) |=> s_final_read)
    else $error("Word not taken from a following read");

  a_toggle_stopped: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (s_eval_now and mode_q == FWSR_MODE_TOGGLE && ph_q != FWSR_PH_FIRST && same)
    |=> s_final_read)
    else $error("Unchanged toggle bit not treated as done");

  a_first_pair: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (s_eval_now and mode_q == FWSR_MODE_TOGGLE && ph_q == FWSR_PH_FIRST)
    |=> st_q == FWSR_READ && ph_q == FWSR_PH_POLL)
    else $error("Toggle polling did not take a second read");

  a_fail_reset: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    $rose(fail_q) |-> $past(pins_q.we_n) == 1'b0 && $past(pins_q.dq_oe_n) == 1'b0
      && $past(pins_q.dq_o) == RESET_CMD)
    else $error("Failure reported without a reset command");

  a_restart_first: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    start_p && !abort_p |=> st_q == FWSR_READ && ph_q == FWSR_PH_FIRST ##1 !pins_q.oe_n)
    else $error("Polling did not restart at the first step");

  a_limit_recheck: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    (s_eval_now and mode_q == FWSR_MODE_DATA && !match && rd_q[DQ_LIMIT]
     && ph_q != FWSR_PH_RECHECK) |=> ph_q == FWSR_PH_RECHECK && st_q == FWSR_READ)
    else $error("Polling bit not rechecked after limit flag");

endmodule

// *** fwsr_pkg.sv ***
package fwsr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_EXPECT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RESULT = 8'h10;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ABORT = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG1 = 6;
  localparam int DQ_LIMIT = 5;

  // Reset values and the flash reset command word
  localparam logic [22:0] ADDR_RST = 23'h000000;
  localparam logic [15:0] EXPECT_RST = 16'h0000;
  localparam logic [15:0] RESET_CMD = 16'h00f0;

  // ----------------------------------------------------------------
  // Timing: strobe widths in ns, cycle counts rounded up
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_READ_NS = 70;
  localparam int T_WE_NS = 35;
  localparam int READ_CYC = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_CYC = (T_WE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [15:0] dq_o;
    logic [22:0] addr;
  } fwsr_pins_t;

  typedef enum logic {FWSR_MODE_DATA, FWSR_MODE_TOGGLE} fwsr_mode_t;
  typedef enum {FWSR_IDLE, FWSR_READ, FWSR_EVAL, FWSR_WRITE} fwsr_state_t;
  typedef enum {FWSR_PH_FIRST, FWSR_PH_POLL, FWSR_PH_RECHECK, FWSR_PH_FINAL} fwsr_phase_t;

endpackage

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import fwsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  fwsr_pins_t flash_pins;
  logic [15:0] flash_dq_i;
  logic [15:0] dev_dq;
  logic flash_ready_busy_i;
  logic arm = 1'b0;
  logic [7:0] arm_reads = 8'h01;
  logic [15:0] arm_datum = 16'h0;
  logic arm_erase = 1'b0;
  logic arm_fail = 1'b0;
  logic arm_prot = 1'b0;
  logic suspend = 1'b0;
  logic [7:0] resets_seen;
  logic [31:0] rd;
  logic [22:0] fa;
  logic [15:0] arr_exp;
  int err_count = 0;
  int n_compared = 0;
  int nres = 0;

  // ----------------------------------------
  // Clock, lines and instances
  // ----------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  // The controller owns the lines only while its enable is low
  assign flash_dq_i = flash_pins.dq_oe_n ? dev_dq : flash_pins.dq_o;

  fwsr_host_ctrl dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_pins, .flash_dq_i,
    .flash_ready_busy_i);
  fwsr_flash_model dev_u (.clk, .pins(flash_pins), .bus_i(flash_dq_i), .arm, .arm_reads,
    .arm_datum, .arm_erase, .arm_fail, .arm_prot, .suspend, .dq(dev_dq),
    .ready_busy(flash_ready_busy_i),
    .resets_seen);

  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bus response got %b exp %b", $time, got, exp);
    end
  endtask

  // Starts one edge late so a strobe is never assigned twice in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk_resp(s_axi_rresp, er);
  endtask

  task automatic arm_dev(input logic [7:0] n, input logic [15:0] d, input logic e,
                         input logic f);
    @(posedge clk);
    arm <= 1'b1;
    arm_reads <= n;
    arm_datum <= d;
    arm_erase <= e;
    arm_fail <= f;
    @(posedge clk);
    arm <= 1'b0;
  endtask

  // Poll until idle, then once more: the ready pin trails a reset command by a cycle
  task automatic poll_idle();
    for (int k = 0; k < 400; k++) begin
      axi_rd(OFF_STATUS, 2'b00);
      if (rd[STAT_BUSY] === 1'b0) break;
    end
    axi_rd(OFF_STATUS, 2'b00);
  endtask

  // One polled operation; the expected outcome follows from the model's setup
  task automatic run_op(input logic m, input logic [7:0] n, input logic [15:0] d,
                        input logic e, input logic f);
    fa = 23'($urandom);
    axi_wr(OFF_ADDR, {9'h0, fa}, 2'b00);
    axi_wr(OFF_EXPECT, {16'h0, d}, 2'b00);
    arm_dev(n, d, e, f);
    axi_rd(OFF_STATUS, 2'b00);
    chk_word({31'h0, rd[3]}, 32'h1, "device busy");
    axi_wr(OFF_CTRL, (32'(m) << CTRL_MODE) | 32'h1, 2'b00);
    axi_rd(OFF_CTRL, 2'b00);
    chk_word(rd, 32'(m) << CTRL_MODE, "mode readback");
    poll_idle();
    if (f) nres++;
    // A protected target leaves the array word as it was
    if (!f && !arm_prot) arr_exp = d;
    chk_word(rd, f ? 32'h4 : 32'h2, "status");
    axi_rd(OFF_RESULT, 2'b00);
    if (!f) chk_word(rd, {16'h0, arr_exp}, "result word");
    chk_word(32'(flash_pins.addr), 32'(fa), "poll address");
    chk_word(32'(resets_seen), 32'(nres), "reset commands");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rd = $urandom(46430);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk_word({28'h0, flash_pins.ce_n, flash_pins.oe_n, flash_pins.we_n, flash_pins.dq_oe_n},
             32'hf, "idle strobes");
    axi_rd(OFF_ADDR, 2'b00);
    chk_word(rd, 32'(ADDR_RST), "addr reset");
    axi_rd(OFF_EXPECT, 2'b00);
    chk_word(rd, 32'(EXPECT_RST), "expect reset");
    axi_rd(OFF_STATUS, 2'b00);
    chk_word(rd, 32'h0, "status reset");
    axi_wr(8'h14, 32'h1, 2'b10);
    axi_rd(8'h14, 2'b10);
    chk_word(rd, 32'h0, "unmapped read");
    // Both modes; program and erase words; a one-read corner; timing-limit failures
    for (int i = 0; i < 6; i++)
      run_op(i[0], (i == 0) ? 8'h01 : 8'(1 + $urandom % 6),
             (i == 2 || i == 3) ? 16'hffff : 16'($urandom), i == 2 || i == 3, i >= 4);
    // Abort mid-poll: busy and done clear, then a fresh operation restarts
    arm_dev(8'd40, 16'h00aa, 1'b0, 1'b0);
    axi_wr(OFF_CTRL, 32'h1, 2'b00);
    axi_wr(OFF_CTRL, 32'h1 << CTRL_ABORT, 2'b00);
    axi_rd(OFF_STATUS, 2'b00);
    chk_word(rd, 32'h8, "status after abort");
    run_op(1'b1, 8'h03, 16'($urandom), 1'b0, 1'b0);
    // Protected targets: a busy window, then the old word in array mode
    arm_prot <= 1'b1;
    run_op(1'b1, 8'h04, 16'($urandom), 1'b0, 1'b0);
    run_op(1'b1, 8'h04, 16'hffff, 1'b1, 1'b0);
    arm_prot <= 1'b0;
    // Erase suspend: toggle bit freezes, polling bit reads one, ready pin released
    arm_dev(8'h05, 16'hffff, 1'b1, 1'b0);
    suspend <= 1'b1;
    axi_wr(OFF_CTRL, (32'h1 << CTRL_MODE) | 32'h1, 2'b00);
    poll_idle();
    chk_word(rd, 32'h2, "suspended status");
    axi_rd(OFF_RESULT, 2'b00);
    chk_word({31'h0, rd[7]}, 32'h1, "suspended polling bit");
    suspend <= 1'b0;
    print_verdict();
  end

  // Watchdog: far beyond the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
